/* File: inc/psac_consts.svh */
// constants of the page-read and configuration-access link
// assumes a 50 MHz clock shared by both ends
`ifndef PSAC_CONSTS_SVH
`define PSAC_CONSTS_SVH
`define PSAC_AW 23
`define PSAC_DW 16
`define PSAC_MEM_AW 6
`define PSAC_CLK_NS 20
`define PSAC_T_RAND_NS 70
`define PSAC_T_PAGE_NS 20
`define PSAC_T_WR_NS 70
`define PSAC_RAND_CYC ((`PSAC_T_RAND_NS + `PSAC_CLK_NS - 1) / `PSAC_CLK_NS)
`define PSAC_PAGE_CYC ((`PSAC_T_PAGE_NS + `PSAC_CLK_NS - 1) / `PSAC_CLK_NS)
`define PSAC_WR_CYC ((`PSAC_T_WR_NS + `PSAC_CLK_NS - 1) / `PSAC_CLK_NS)
`define PSAC_HOST_MARGIN 2
`define PSAC_SEL_HI 19
`define PSAC_SEL_LO 18
`define PSAC_PAGE_MODE_BIT 7
`define PSAC_SLEEP_BIT 4
`define PSAC_ASYNC_BIT 15
`define PSAC_PSIZE_HI 9
`define PSAC_PSIZE_LO 8
`define PSAC_BCR_RST 16'h8010
`define PSAC_RCR_RST 16'h0010
// arbitrary identification value
`define PSAC_ID_VAL 16'h5A31
`define PSAC_LANE_IDLE 8'hFF
`endif

/* File: inc/psac_pkg.sv */
// types shared by both ends of the link
// assumes psac_consts.svh for the numbers
package psac_pkg;
  typedef enum logic [1:0] {
    PSAC_DEV_IDLE = 2'b00,
    PSAC_DEV_READ = 2'b01,
    PSAC_DEV_WRITE = 2'b10,
    PSAC_DEV_SLEEP = 2'b11
  } psac_dev_state_t;
  typedef enum logic [2:0] {
    PSAC_H_IDLE = 3'b000,
    PSAC_H_READ = 3'b001,
    PSAC_H_HOLD = 3'b010,
    PSAC_H_WRITE = 3'b011,
    PSAC_H_WEND = 3'b100
  } psac_host_state_t;
endpackage

/* File: inc/psac_if.sv */
// pin bundle between host controller and memory device
// assumes both ends share one clock; dq resolved here with pull-up
`timescale 1ns/100ps
`default_nettype none
`include "psac_consts.svh"
interface psac_if;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic high_lane_n;
  logic low_lane_n;
  logic latch_n;
  logic config_reg_select;
  logic mem_clk;
  logic [`PSAC_AW-1:0] addr;
  logic [`PSAC_DW-1:0] host_dq;
  logic [1:0] host_dq_oe_n;
  logic [`PSAC_DW-1:0] dev_dq;
  logic [1:0] dev_dq_oe_n;
  logic [`PSAC_DW-1:0] dq;
  assign dq[7:0] = !dev_dq_oe_n[0] ? dev_dq[7:0] :
    !host_dq_oe_n[0] ? host_dq[7:0] : `PSAC_LANE_IDLE;
  assign dq[15:8] = !dev_dq_oe_n[1] ? dev_dq[15:8] :
    !host_dq_oe_n[1] ? host_dq[15:8] : `PSAC_LANE_IDLE;
  modport dev (
    input ce_n, oe_n, we_n, high_lane_n, low_lane_n, latch_n,
    input config_reg_select, mem_clk, addr, dq,
    output dev_dq, dev_dq_oe_n
  );
  modport host (
    output ce_n, oe_n, we_n, high_lane_n, low_lane_n, latch_n,
    output config_reg_select, mem_clk, addr, host_dq, host_dq_oe_n,
    input dq
  );
endinterface
`default_nettype wire

/* File: rtl/psac_device.sv */
// memory device end: async reads, page reads, writes, config access
// assumes host pins come from flops on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "psac_consts.svh"
module psac_device
  import psac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  psac_if.dev bus,
  // status
  output logic deep_sleep,
  output logic async_mode,
  output logic page_mode,
  output logic page_hit,
  output logic clk_fault
);
  localparam int MEM_WORDS = 1 << `PSAC_MEM_AW;

  psac_dev_state_t state_reg, state_next;
  logic [`PSAC_DW-1:0] bcr_reg, bcr_next;
  logic [`PSAC_DW-1:0] rcr_reg, rcr_next;
  logic [`PSAC_AW-1:0] addr_lat_reg, addr_lat_next;
  logic [`PSAC_AW-1:0] rd_addr_reg, rd_addr_next;
  logic rd_cr_reg, rd_cr_next;
  logic [3:0] cnt_reg, cnt_next;
  logic page_valid_reg, page_valid_next;
  logic hit_reg, hit_next;
  logic [`PSAC_DW-1:0] dout_reg, dout_next;
  logic [1:0] oe_n_reg, oe_n_next;
  logic fault_reg, fault_next;
  logic wr_arm_reg, wr_arm_next;
  logic [`PSAC_AW-1:0] ws_addr_reg, ws_addr_next;
  logic [`PSAC_DW-1:0] ws_data_reg, ws_data_next;
  logic [1:0] ws_lane_n_reg, ws_lane_n_next;
  logic ws_cr_reg, ws_cr_next;
  logic [`PSAC_DW-1:0] mem [0:MEM_WORDS-1];

  logic [`PSAC_AW-1:0] addr_eff;
  logic active, rd, wr, wr_arm, commit, same_page, new_access;
  logic [3:0] pmask;
  logic [`PSAC_DW-1:0] reg_val, rd_val, mem_old, mem_new;
  logic mem_we;

  assign async_mode = bcr_reg[`PSAC_ASYNC_BIT];
  assign page_mode = rcr_reg[`PSAC_PAGE_MODE_BIT];
  assign deep_sleep = (state_reg == PSAC_DEV_SLEEP);
  assign page_hit = hit_reg;
  assign clk_fault = fault_reg;
  assign bus.dev_dq = dout_reg;
  assign bus.dev_dq_oe_n = oe_n_reg;

  always_comb begin
    // address follows pins while latch is low, holds from its rise
    addr_eff = bus.latch_n ? addr_lat_reg : bus.addr;
    addr_lat_next = addr_eff;
    // mem_clk high is treated as a non-async cycle
    active = !bus.ce_n && async_mode && !bus.mem_clk &&
      (state_reg != PSAC_DEV_SLEEP);
    rd = active && bus.we_n && !bus.oe_n;
    wr = active && !bus.we_n;
    wr_arm = wr && (bus.config_reg_select ||
      !(bus.high_lane_n && bus.low_lane_n));
    commit = wr_arm_reg && !wr_arm;
    unique case (rcr_reg[`PSAC_PSIZE_HI:`PSAC_PSIZE_LO])
      2'b00: pmask = 4'h3;
      2'b01: pmask = 4'h7;
      default: pmask = 4'hF;
    endcase
    same_page = (addr_eff[`PSAC_AW-1:4] == rd_addr_reg[`PSAC_AW-1:4]) &&
      ((addr_eff[3:0] & ~pmask) == (rd_addr_reg[3:0] & ~pmask));
    if (addr_eff[`PSAC_SEL_LO]) begin
      reg_val = `PSAC_ID_VAL;
    end else if (addr_eff[`PSAC_SEL_HI]) begin
      reg_val = bcr_reg;
    end else begin
      reg_val = rcr_reg;
    end
    rd_val = bus.config_reg_select ? reg_val :
      mem[addr_eff[`PSAC_MEM_AW-1:0]];
    new_access = rd && (state_reg != PSAC_DEV_READ ||
      addr_eff != rd_addr_reg || bus.config_reg_select != rd_cr_reg);
  end

  // read path
  always_comb begin
    rd_addr_next = rd_addr_reg;
    rd_cr_next = rd_cr_reg;
    cnt_next = cnt_reg;
    page_valid_next = page_valid_reg;
    hit_next = hit_reg;
    dout_next = dout_reg;
    oe_n_next = 2'h3;
    if (!rd) begin
      cnt_next = 4'h0;
    end
    if (bus.ce_n || !page_mode) begin
      page_valid_next = 1'b0;
    end
    if (new_access) begin
      rd_addr_next = addr_eff;
      rd_cr_next = bus.config_reg_select;
      // any word of an open page is fast, in any order
      if (page_mode && page_valid_reg && same_page &&
          !bus.config_reg_select) begin
        cnt_next = 4'(`PSAC_PAGE_CYC);
        hit_next = 1'b1;
      end else begin
        cnt_next = 4'(`PSAC_RAND_CYC);
        hit_next = 1'b0;
        page_valid_next = 1'b0;
      end
    end else if (rd && cnt_reg == 4'h1) begin
      cnt_next = 4'h0;
      dout_next = rd_val;
      page_valid_next = page_mode && !rd_cr_reg;
    end else if (rd && cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
    end
    if (rd) begin
      oe_n_next = bus.config_reg_select ? 2'h0 :
        {bus.high_lane_n, bus.low_lane_n};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_addr_reg <= '0;
      rd_cr_reg <= 1'b0;
      cnt_reg <= 4'h0;
      page_valid_reg <= 1'b0;
      hit_reg <= 1'b0;
      dout_reg <= 16'h0000;
      oe_n_reg <= 2'h3;
      addr_lat_reg <= '0;
    end else begin
      rd_addr_reg <= rd_addr_next;
      rd_cr_reg <= rd_cr_next;
      cnt_reg <= cnt_next;
      page_valid_reg <= page_valid_next;
      hit_reg <= hit_next;
      dout_reg <= dout_next;
      oe_n_reg <= oe_n_next;
      addr_lat_reg <= addr_lat_next;
    end
  end

  // write capture, committed on the first releasing edge
  always_comb begin
    wr_arm_next = wr_arm;
    ws_addr_next = ws_addr_reg;
    ws_data_next = ws_data_reg;
    ws_lane_n_next = ws_lane_n_reg;
    ws_cr_next = ws_cr_reg;
    if (wr_arm) begin
      ws_addr_next = addr_eff;
      ws_data_next = bus.dq;
      ws_lane_n_next = {bus.high_lane_n, bus.low_lane_n};
      ws_cr_next = bus.config_reg_select;
    end
    // every write is a single random access
    mem_we = commit && !ws_cr_reg;
    mem_old = mem[ws_addr_reg[`PSAC_MEM_AW-1:0]];
    mem_new = {ws_lane_n_reg[1] ? mem_old[15:8] : ws_data_reg[15:8],
      ws_lane_n_reg[0] ? mem_old[7:0] : ws_data_reg[7:0]};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_arm_reg <= 1'b0;
      ws_addr_reg <= '0;
      ws_data_reg <= 16'h0000;
      ws_lane_n_reg <= 2'h3;
      ws_cr_reg <= 1'b0;
    end else begin
      wr_arm_reg <= wr_arm_next;
      ws_addr_reg <= ws_addr_next;
      ws_data_reg <= ws_data_next;
      ws_lane_n_reg <= ws_lane_n_next;
      ws_cr_reg <= ws_cr_next;
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[ws_addr_reg[`PSAC_MEM_AW-1:0]] <= mem_new;
    end
  end

  // configuration registers and power state
  always_comb begin
    bcr_next = bcr_reg;
    rcr_next = rcr_reg;
    state_next = state_reg;
    fault_next = !bus.ce_n && bus.mem_clk;
    if (commit && ws_cr_reg && !ws_addr_reg[`PSAC_SEL_LO]) begin
      // value comes from the address lines; id is read-only
      if (ws_addr_reg[`PSAC_SEL_HI]) begin
        bcr_next = ws_addr_reg[`PSAC_DW-1:0];
      end else begin
        rcr_next = ws_addr_reg[`PSAC_DW-1:0];
      end
    end
    unique case (state_reg)
      PSAC_DEV_SLEEP: begin
        if (!bus.ce_n) begin
          state_next = PSAC_DEV_IDLE;
          rcr_next[`PSAC_SLEEP_BIT] = 1'b1;
        end
      end
      default: begin
        if (bus.ce_n && !bus.config_reg_select &&
            !rcr_reg[`PSAC_SLEEP_BIT] && !bcr_reg[`PSAC_SLEEP_BIT]) begin
          state_next = PSAC_DEV_SLEEP;
        end else if (rd) begin
          state_next = PSAC_DEV_READ;
        end else if (wr_arm) begin
          state_next = PSAC_DEV_WRITE;
        end else begin
          state_next = PSAC_DEV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bcr_reg <= `PSAC_BCR_RST;
      rcr_reg <= `PSAC_RCR_RST;
      state_reg <= PSAC_DEV_IDLE;
      fault_reg <= 1'b0;
    end else begin
      bcr_reg <= bcr_next;
      rcr_reg <= rcr_next;
      state_reg <= state_next;
      fault_reg <= fault_next;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/psac_host.sv */
// host controller end: issues reads, page reads, writes, config access
// assumes the device end samples pins on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "psac_consts.svh"
module psac_host
  import psac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_reg,
  input wire logic [`PSAC_AW-1:0] req_addr,
  input wire logic [`PSAC_DW-1:0] req_wdata,
  input wire logic [1:0] req_lane_n,
  // settings mirrored from the device registers
  input wire logic page_en,
  input wire logic [1:0] page_size,
  input wire logic sleep_hold,
  // answer
  output logic rsp_valid,
  output logic [`PSAC_DW-1:0] rsp_rdata,
  // pins
  psac_if.host bus
);
  psac_host_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic ce_n_reg, ce_n_next;
  logic oe_n_reg, oe_n_next;
  logic we_n_reg, we_n_next;
  logic [1:0] lane_n_reg, lane_n_next;
  logic latch_n_reg, latch_n_next;
  logic cr_reg, cr_next;
  logic [`PSAC_AW-1:0] addr_reg, addr_next;
  logic [`PSAC_DW-1:0] wd_reg, wd_next;
  logic [1:0] dq_oe_n_reg, dq_oe_n_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [`PSAC_DW-1:0] rdata_reg, rdata_next;
  logic [3:0] pmask;
  logic page_ok, take;

  assign bus.ce_n = ce_n_reg;
  assign bus.oe_n = oe_n_reg;
  assign bus.we_n = we_n_reg;
  assign bus.high_lane_n = lane_n_reg[1];
  assign bus.low_lane_n = lane_n_reg[0];
  assign bus.latch_n = latch_n_reg;
  assign bus.config_reg_select = cr_reg;
  assign bus.mem_clk = 1'b0;
  assign bus.addr = addr_reg;
  assign bus.host_dq = wd_reg;
  assign bus.host_dq_oe_n = dq_oe_n_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rdata_reg;

  always_comb begin
    unique case (page_size)
      2'b00: pmask = 4'h3;
      2'b01: pmask = 4'h7;
      default: pmask = 4'hF;
    endcase
    // only low in-page bits may move while the page stays open
    page_ok = page_en && !req_write && !req_reg && !sleep_hold &&
      (req_addr[`PSAC_AW-1:4] == addr_reg[`PSAC_AW-1:4]) &&
      ((req_addr[3:0] & ~pmask) == (addr_reg[3:0] & ~pmask));
    // sleep_hold keeps ce high for deep sleep
    req_ready = (state_reg == PSAC_H_IDLE && !sleep_hold) ||
      (state_reg == PSAC_H_HOLD && page_ok);
    take = req_valid && req_ready;
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ce_n_next = ce_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    lane_n_next = lane_n_reg;
    latch_n_next = latch_n_reg;
    cr_next = cr_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    dq_oe_n_next = dq_oe_n_reg;
    rsp_valid_next = 1'b0;
    rdata_next = rdata_reg;
    unique case (state_reg)
      PSAC_H_IDLE: begin
        ce_n_next = 1'b1;
        oe_n_next = 1'b1;
        we_n_next = 1'b1;
        cr_next = 1'b0;
        dq_oe_n_next = 2'h3;
        if (take) begin
          ce_n_next = 1'b0;
          latch_n_next = 1'b0;
          lane_n_next = req_lane_n;
          cr_next = req_reg;
          addr_next = req_addr;
          if (req_write) begin
            we_n_next = 1'b0;
            cnt_next = 4'(`PSAC_WR_CYC);
            wd_next = req_wdata;
            if (req_reg) begin
              // register value rides on the address lines
              addr_next = {req_addr[`PSAC_AW-1:`PSAC_DW], req_wdata};
              dq_oe_n_next = 2'h3;
            end else begin
              dq_oe_n_next = req_lane_n;
            end
            state_next = PSAC_H_WRITE;
          end else begin
            oe_n_next = 1'b0;
            cnt_next = 4'(`PSAC_RAND_CYC + `PSAC_HOST_MARGIN);
            state_next = PSAC_H_READ;
          end
        end
      end
      PSAC_H_READ: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          rdata_next = bus.dq;
          rsp_valid_next = 1'b1;
          state_next = PSAC_H_HOLD;
        end
      end
      PSAC_H_HOLD: begin
        // ce and latch stay low across the page
        if (take) begin
          addr_next = req_addr;
          lane_n_next = req_lane_n;
          cnt_next = 4'(`PSAC_PAGE_CYC + `PSAC_HOST_MARGIN);
          state_next = PSAC_H_READ;
        end else if (req_valid || sleep_hold || !page_en) begin
          state_next = PSAC_H_IDLE;
          ce_n_next = 1'b1;
          oe_n_next = 1'b1;
        end
      end
      PSAC_H_WRITE: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          we_n_next = 1'b1;
          state_next = PSAC_H_WEND;
        end
      end
      PSAC_H_WEND: begin
        rsp_valid_next = 1'b1;
        ce_n_next = 1'b1;
        dq_oe_n_next = 2'h3;
        state_next = PSAC_H_IDLE;
      end
      default: begin
        state_next = PSAC_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= PSAC_H_IDLE;
      cnt_reg <= 4'h0;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      lane_n_reg <= 2'h3;
      latch_n_reg <= 1'b0;
      cr_reg <= 1'b0;
      addr_reg <= '0;
      wd_reg <= 16'h0000;
      dq_oe_n_reg <= 2'h3;
      rsp_valid_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ce_n_reg <= ce_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      lane_n_reg <= lane_n_next;
      latch_n_reg <= latch_n_next;
      cr_reg <= cr_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      dq_oe_n_reg <= dq_oe_n_next;
      rsp_valid_reg <= rsp_valid_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule
`default_nettype wire

/* File: verif/psac_props.sv */
// checker for the pin rules between the host and device ends
// assumes one clock and the psac_if pins as plain inputs
`timescale 1ns/100ps
`default_nettype none
`include "psac_consts.svh"
module psac_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic high_lane_n,
  input wire logic latch_n,
  input wire logic config_reg_select,
  input wire logic mem_clk,
  input wire logic [`PSAC_AW-1:0] addr,
  input wire logic [1:0] host_dq_oe_n,
  input wire logic [1:0] dev_dq_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  clk_low_a: assert property (!mem_clk)
    else $error("memory clock high");
  latch_hold_a: assert property (!ce_n && !oe_n |-> !latch_n)
    else $error("latch released during read");
  page_addr_a: assert property (
    !ce_n && $past(!ce_n) && !oe_n && $past(!oe_n) && !config_reg_select
    |-> addr[22:4] == $past(addr[22:4]))
    else $error("page address moved");
  write_pulse_a: assert property (
    $fell(we_n) |-> !we_n [*4] ##1 we_n)
    else $error("write strobe length wrong");
  write_override_a: assert property (
    !we_n && $past(!we_n) |-> &dev_dq_oe_n)
    else $error("device drives during write");
  standby_off_a: assert property (
    ce_n && $past(ce_n) && !config_reg_select |-> &dev_dq_oe_n)
    else $error("device drives in standby");
  read_drive_a: assert property (
    !dev_dq_oe_n[0] |-> $past(!ce_n && we_n && !oe_n))
    else $error("device drives outside read");
  lane_read_a: assert property (
    !dev_dq_oe_n[1] |-> $past(!high_lane_n) || $past(config_reg_select))
    else $error("disabled upper lane driven");
  lane_write_a: assert property (
    !host_dq_oe_n[1] && !config_reg_select |-> !high_lane_n)
    else $error("host drives disabled lane");
endmodule
`default_nettype wire

/* File: verif/psram_async_page_read_and_cfg_access_tb.sv */
// self-checking bench joining the host and device ends
// assumes design files and psac_props are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "psac_consts.svh"
module psram_async_page_read_and_cfg_access_tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic req_valid = 1'h0, req_write = 1'h0, req_reg = 1'h0;
  logic page_en = 1'h0, sleep_hold = 1'h0, req_ready, rsp_valid;
  logic [`PSAC_AW-1:0] req_addr = 23'h0;
  logic [`PSAC_DW-1:0] req_wdata = 16'h0, rsp_rdata;
  logic [1:0] req_lane_n = 2'h0, page_size = 2'h0;
  logic deep_sleep, async_mode, page_mode, page_hit, clk_fault;
  logic [15:0] rst_tab [4] = '{`PSAC_RCR_RST, `PSAC_ID_VAL,
    `PSAC_BCR_RST, `PSAC_ID_VAL};
  int pa [6] = '{2, 1, 3, 0, 5, 4};
  logic [5:0] fast = 6'h2E;
  int mismatches = 0, cmp_count = 0, cycles = 0, lat;
  psac_if bus ();
  always #10 clk = ~clk;
  psac_host psac_host_i (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_reg(req_reg),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_lane_n(req_lane_n),
    .page_en(page_en), .page_size(page_size), .sleep_hold(sleep_hold),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus(bus.host));
  psac_device psac_device_i (.clk(clk), .rst_n(rst_n), .bus(bus.dev),
    .deep_sleep(deep_sleep), .async_mode(async_mode),
    .page_mode(page_mode), .page_hit(page_hit), .clk_fault(clk_fault));
  psac_props psac_props_i (.clk(clk), .rst_n(rst_n), .ce_n(bus.ce_n),
    .oe_n(bus.oe_n), .we_n(bus.we_n), .high_lane_n(bus.high_lane_n),
    .latch_n(bus.latch_n), .config_reg_select(bus.config_reg_select),
    .mem_clk(bus.mem_clk), .addr(bus.addr),
    .host_dq_oe_n(bus.host_dq_oe_n), .dev_dq_oe_n(bus.dev_dq_oe_n));
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    mismatches++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) fail($sformatf("word %h expected %h", got, exp));
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
  endtask
  task automatic chk_cnt(input int got, input int exp);
    cmp_count++;
    if (got != exp) fail($sformatf("latency %0d expected %0d", got, exp));
  endtask
  // one request through the host port; lat counts edges to the answer
  task automatic xfer(input logic w, input logic r, input logic [22:0] a,
      input logic [15:0] d, input logic [1:0] ln);
    int n;
    @(posedge clk);
    req_valid <= 1'h1;
    req_write <= w;
    req_reg <= r;
    req_addr <= a;
    req_wdata <= d;
    req_lane_n <= ln;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'h1 && n < 50);
    if (req_ready !== 1'h1) fail("request not taken");
    req_valid <= 1'h0;
    lat = 0;
    do begin
      @(posedge clk);
      #1;
      lat++;
    end while (rsp_valid !== 1'h1 && lat < 50);
    if (rsp_valid !== 1'h1) fail("no answer");
  endtask
  task automatic rd(input logic r, input logic [22:0] a,
      input logic [1:0] ln, input logic [15:0] exp);
    xfer(1'h0, r, a, 16'h0, ln);
    chk_word(rsp_rdata, exp);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail("run too long");
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      rd(1'h1, {3'h0, 2'(i), 18'h0}, 2'h0, rst_tab[i]);
    end
    chk_flag(async_mode, 1'h1);
    chk_flag(page_mode, 1'h0);
    $display("test register reset values done");
    xfer(1'h1, 1'h1, 23'h040000, 16'h1234, 2'h0);
    rd(1'h1, 23'h040000, 2'h0, `PSAC_ID_VAL);
    $display("test read-only identification done");
    xfer(1'h1, 1'h0, 23'h3, 16'hA5C3, 2'h0);
    chk_cnt(lat, `PSAC_WR_CYC + 1);
    xfer(1'h1, 1'h0, 23'h3, 16'h0011, 2'h2);
    rd(1'h0, 23'h3, 2'h0, 16'hA511);
    rd(1'h0, 23'h3, 2'h1, {8'hA5, `PSAC_LANE_IDLE});
    chk_cnt(lat, `PSAC_RAND_CYC + 2);
    $display("test byte lanes done");
    xfer(1'h1, 1'h1, 23'h0, 16'h0090, 2'h0);
    chk_flag(page_mode, 1'h1);
    page_en <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      xfer(1'h1, 1'h0, 23'(i), 16'hC000 + 16'(i), 2'h0);
      chk_cnt(lat, `PSAC_WR_CYC + 1);
    end
    for (int i = 0; i < 6; i++) begin
      rd(1'h0, 23'(pa[i]), 2'h0, 16'hC000 + 16'(pa[i]));
      chk_cnt(lat, fast[i] ? `PSAC_PAGE_CYC + 2 : `PSAC_RAND_CYC + 2);
      chk_flag(page_hit, fast[i]);
    end
    xfer(1'h1, 1'h0, 23'h9, 16'h5A09, 2'h0);
    for (int s = 1; s < 3; s++) begin
      xfer(1'h1, 1'h1, 23'h0, {6'h00, 2'(s), 8'h90}, 2'h0);
      page_size <= 2'(s);
      rd(1'h0, 23'h0, 2'h0, 16'hC000);
      chk_cnt(lat, `PSAC_RAND_CYC + 2);
      if (s == 1) begin
        rd(1'h0, 23'h7, 2'h0, 16'hC007);
      end else begin
        rd(1'h0, 23'h9, 2'h0, 16'h5A09);
      end
      chk_cnt(lat, `PSAC_PAGE_CYC + 2);
    end
    $display("test page reads done");
    page_en <= 1'h0;
    xfer(1'h1, 1'h1, 23'h080000, 16'h8000, 2'h0);
    xfer(1'h1, 1'h1, 23'h0, 16'h0000, 2'h0);
    sleep_hold <= 1'h1;
    repeat (3) @(posedge clk);
    chk_flag(deep_sleep, 1'h1);
    chk_flag(req_ready, 1'h0);
    chk_word(bus.dq, 16'hFFFF);
    sleep_hold <= 1'h0;
    xfer(1'h0, 1'h0, 23'h0, 16'h0, 2'h0);
    rd(1'h1, 23'h0, 2'h0, 16'h0010);
    chk_flag(deep_sleep, 1'h0);
    chk_flag(clk_fault, 1'h0);
    xfer(1'h1, 1'h1, 23'h080000, 16'h0010, 2'h0);
    chk_flag(async_mode, 1'h0);
    rd(1'h0, 23'h3, 2'h0, 16'hFFFF);
    $display("test deep sleep done");
    summarize();
  end
endmodule
`default_nettype wire
